// file: include/an_np_defs.svh
// Offsets, field positions and reset values of the next page transmit block.
// Plain constants only; included by the package, whose inclusion makes them visible to the design modules.
`ifndef AN_NP_DEFS_SVH
`define AN_NP_DEFS_SVH

// Register indexes; byte address on the bus is four times the index
`define NP_IDX_EXPANSION 5'h06
`define NP_IDX_NEXT_PAGE 5'h07
`define NP_IDX_STATUS 5'h1e

// Next page word field positions
`define NP_BIT_MORE 15
`define NP_BIT_RSVD 14
`define NP_BIT_MSG 13
`define NP_BIT_COMPLY 12
`define NP_BIT_TOGGLE 11
`define NP_CODE_HI 10
`define NP_CODE_LO 0

// Next page word reset values
`define NP_RST_MORE 1'b0
`define NP_RST_MSG 1'b1
`define NP_RST_COMPLY 1'b0
`define NP_RST_TOGGLE 1'b0
`define NP_RST_CODE 11'h001

// Expansion status field position and value
`define NP_BIT_LOCAL_CAPABLE 2
`define NP_LOCAL_CAPABLE 1'b1

// Status register field positions
`define NP_ST_FRESH 0
`define NP_ST_STALE 1
`define NP_ST_COUNT_HI 15
`define NP_ST_COUNT_LO 8

`endif

// file: include/an_np_pkg.sv
// Types shared by the next page transmit block and its helper modules.
// Assumes the constants header sits on the include path.
package an_np_pkg;
  `include "an_np_defs.svh"

  typedef logic [15:0] word_t;
  typedef logic [10:0] code_t;

  // Bus slave phase
  typedef enum logic {ph_idle, ph_access} apb_phase_e;

  // Register selected by an address
  typedef enum logic [1:0] {sel_none, sel_expansion, sel_next_page, sel_status} reg_sel_e;

  typedef struct packed {
    apb_phase_e phase;
    logic [31:0] rdata;
    logic err;
  } apb_port_s;

  typedef struct packed {
    logic toggle;
  } toggle_s;

  typedef struct packed {
    logic more;
    logic msg;
    logic comply;
    code_t code;
    word_t tx_word;
    logic fresh;
    logic stale;
    logic [7:0] sent_count;
  } np_state_s;
endpackage

// file: hw/np_toggle_track.sv
// Keeps the toggle bit of the next page word opposite to the last exchange.
// Assumes the exchange pulse comes from arbitration logic on the same clock.
`timescale 1ns/10ps
module np_toggle_track (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic clk_en_in,
  input wire logic exchange_done_in,
  input wire logic exchanged_toggle_in,
  output logic toggle_out
);
  import an_np_pkg::*;

  toggle_s state_q;
  toggle_s state_d;

  // Next toggle value
  always_comb begin
    state_d = state_q;
    if (exchange_done_in) begin
      state_d.toggle = ~exchanged_toggle_in;
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      state_q <= '{toggle: `NP_RST_TOGGLE};
    end else if (clk_en_in) begin
      state_q <= state_d;
    end
  end

  assign toggle_out = state_q.toggle;
endmodule // np_toggle_track

// file: hw/np_apb_port.sv
// APB slave handshake: captures read data in the setup phase, answers in
// the first access cycle. Assumes the caller decodes the address.
`timescale 1ns/10ps
module np_apb_port (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic clk_en_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] rd_value_in,
  input wire logic addr_bad_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic wr_stb_out
);
  import an_np_pkg::*;

  apb_port_s state_q;
  apb_port_s state_d;
  logic done;

  // Ready is gated by the enable so a frozen block never loses a transfer
  assign done = (state_q.phase == ph_access) && psel_in && penable_in && clk_en_in;

  // Phase tracking and read data capture
  always_comb begin
    state_d = state_q;
    case (state_q.phase)
      ph_idle: begin
        if (psel_in && !penable_in) begin
          state_d.phase = ph_access;
          state_d.err = addr_bad_in;
          state_d.rdata = pwrite_in ? 32'h0000_0000 : rd_value_in;
        end
      end
      ph_access: begin
        if (done) begin
          state_d.phase = ph_idle;
        end
      end
      default: begin
        state_d.phase = ph_idle;
      end
    endcase
  end

  // State register
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      state_q <= '{phase: ph_idle, rdata: 32'h0000_0000, err: 1'b0};
    end else if (clk_en_in) begin
      state_q <= state_d;
    end
  end

  assign pready_out = done;
  assign pslverr_out = done && state_q.err;
  assign prdata_out = state_q.rdata;
  assign wr_stb_out = done && pwrite_in && !state_q.err;
endmodule // np_apb_port

// file: hw/an_next_page_transmit_reg.sv
// Next page transmit register with its APB slave and arbitration hand-off.
// Assumes the arbitration logic runs on clock_in and pulses its strobes
// for one enabled cycle each.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/10ps
module an_next_page_transmit_reg #(
  parameter int ADDR_W = 8
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic clk_en_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic page_take_in,
  input wire logic exchange_done_in,
  input wire logic exchanged_toggle_in,
  output an_np_pkg::word_t tx_word_out,
  output logic local_pages_capable_out,
  output logic word_fresh_out
);
  import an_np_pkg::*;

  // ************************************************************
  // Elaboration checks
  // ************************************************************

  // The highest index needs seven byte address bits
  generate
    if (ADDR_W < 7) begin : g_bad_addr_w
      $error("ADDR_W must be at least 7");
    end
  endgenerate

  // ************************************************************
  // Address decode
  // ************************************************************

  // Maps a byte address to a register; misaligned or unknown is none
  function automatic reg_sel_e reg_sel(input logic [ADDR_W-1:0] addr);
    logic [4:0] idx;
    reg_sel_e sel;
    idx = addr[6:2];
    sel = sel_none;
    if (addr[1:0] == 2'h0 && (addr >> 7) == '0) begin
      case (idx)
        `NP_IDX_EXPANSION: sel = sel_expansion;
        `NP_IDX_NEXT_PAGE: sel = sel_next_page;
        `NP_IDX_STATUS: sel = sel_status;
        default: sel = sel_none;
      endcase
    end
    return sel;
  endfunction

  // ************************************************************
  // State and helper signals
  // ************************************************************

  np_state_s state_q;
  np_state_s state_d;
  logic toggle;
  logic wr_stb;
  logic addr_bad;
  logic [31:0] rd_value;
  word_t cur_word;

  // ************************************************************
  // Helper modules
  // ************************************************************

  // Bus handshake; decode is done here so the port stays generic
  np_apb_port u_apb (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .clk_en_in(clk_en_in),
    .psel_in(psel_in),
    .penable_in(penable_in),
    .pwrite_in(pwrite_in),
    .rd_value_in(rd_value),
    .addr_bad_in(addr_bad),
    .prdata_out(prdata_out),
    .pready_out(pready_out),
    .pslverr_out(pslverr_out),
    .wr_stb_out(wr_stb)
  );

  // Toggle kept opposite to the last link code word exchanged
  np_toggle_track u_toggle (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .clk_en_in(clk_en_in),
    .exchange_done_in(exchange_done_in),
    .exchanged_toggle_in(exchanged_toggle_in),
    .toggle_out(toggle)
  );

  assign addr_bad = (reg_sel(paddr_in) == sel_none);

  // ************************************************************
  // Next page word assembly
  // ************************************************************

  // Current register image as software sees it
  always_comb begin
    cur_word = 16'h0000;
    cur_word[`NP_BIT_MORE] = state_q.more;
    cur_word[`NP_BIT_RSVD] = 1'b0;
    cur_word[`NP_BIT_MSG] = state_q.msg;
    cur_word[`NP_BIT_COMPLY] = state_q.comply;
    cur_word[`NP_BIT_TOGGLE] = toggle;
    // code passed as written, meaning set by page type
    cur_word[`NP_CODE_HI:`NP_CODE_LO] = state_q.code;
  end

  // ************************************************************
  // Read data
  // ************************************************************

  // Read mux; unused bits of every register read as zero
  always_comb begin
    rd_value = 32'h0000_0000;
    case (reg_sel(paddr_in))
      sel_next_page: begin
        rd_value[15:0] = cur_word;
      end
      sel_expansion: begin
        rd_value[`NP_BIT_LOCAL_CAPABLE] = `NP_LOCAL_CAPABLE;
      end
      sel_status: begin
        rd_value[`NP_ST_FRESH] = state_q.fresh;
        rd_value[`NP_ST_STALE] = state_q.stale;
        rd_value[`NP_ST_COUNT_HI:`NP_ST_COUNT_LO] = state_q.sent_count;
      end
      default: begin
        rd_value = 32'h0000_0000;
      end
    endcase
  end

  // ************************************************************
  // Register update
  // ************************************************************

  // Writes and arbitration hand-off; a take samples the old fields
  always_comb begin
    state_d = state_q;
    if (page_take_in) begin
      state_d.tx_word = cur_word;
      state_d.stale = ~state_q.fresh;
      state_d.fresh = 1'b0;
      state_d.sent_count = state_q.sent_count + 8'h01;
    end
    // Software write wins over the take clearing the fresh flag
    if (wr_stb && reg_sel(paddr_in) == sel_next_page) begin
      state_d.more = pwdata_in[`NP_BIT_MORE];
      state_d.msg = pwdata_in[`NP_BIT_MSG];
      state_d.comply = pwdata_in[`NP_BIT_COMPLY];
      state_d.code = pwdata_in[`NP_CODE_HI:`NP_CODE_LO];
      state_d.fresh = 1'b1;
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      state_q <= '{
        more: `NP_RST_MORE,
        msg: `NP_RST_MSG,
        comply: `NP_RST_COMPLY,
        code: `NP_RST_CODE,
        tx_word: 16'h2001,
        fresh: 1'b0,
        stale: 1'b0,
        sent_count: 8'h00
      };
    end else if (clk_en_in) begin
      state_q <= state_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************

  // Word held for the arbitration logic until the next take
  assign tx_word_out = state_q.tx_word;
  assign local_pages_capable_out = `NP_LOCAL_CAPABLE;
  assign word_fresh_out = state_q.fresh;
endmodule // an_next_page_transmit_reg

// file: bench/np_next_page_sva.sv
// Checker for the next page transmit register, watching top ports only.
// Assumes a bind from the bench top; one clock, synchronous low reset.
`timescale 1ns/10ps
module np_next_page_sva #(
  parameter int ADDR_W = 8
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic clk_en_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic page_take_in,
  input wire logic exchange_done_in,
  input wire logic exchanged_toggle_in,
  input wire an_np_pkg::word_t tx_word_out,
  input wire logic local_pages_capable_out,
  input wire logic word_fresh_out
);
  import an_np_pkg::*;
  //****************
  // Properties
  //****************
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  logic wr_acc;
  // Write access phase, shared by the fresh-flag checks
  assign wr_acc = psel_in && penable_in && pwrite_in;
  rsvd_sent_a:
    assert property (tx_word_out[14] == 1'b0) else $error("reserved bit set in sent word");
  toggle_inv_a:
    assert property (clk_en_in && exchange_done_in ##1 clk_en_in && page_take_in
      && !exchange_done_in |=> tx_word_out[11] == !$past(exchanged_toggle_in, 2))
    else $error("toggle bit not inverted");
  ready_next_a:
    assert property (psel_in && !penable_in && clk_en_in ##1 psel_in && penable_in
      && clk_en_in |-> pready_out) else $error("no ready in first access cycle");
  capable_flag_a:
    assert property (local_pages_capable_out == 1'b1) else $error("capable flag low");
  take_hold_a:
    assert property (!(clk_en_in && page_take_in) |=> $stable(tx_word_out))
    else $error("sent word moved without a take");
  take_clear_a:
    assert property (clk_en_in && page_take_in && !wr_acc |=> !word_fresh_out)
    else $error("fresh flag kept after take");
  write_fresh_a:
    assert property (wr_acc && pready_out && !pslverr_out && paddr_in == 8'h1c
      |=> word_fresh_out) else $error("fresh flag not set by write");
  bad_align_a:
    assert property (pready_out && paddr_in[1:0] != 2'h0 |-> pslverr_out
      && (pwrite_in || prdata_out == 32'h0)) else $error("misaligned access accepted");
  read_rsvd_a:
    assert property (pready_out && !pwrite_in && paddr_in == 8'h1c
      |-> prdata_out[31:16] == 16'h0 && !prdata_out[14]) else $error("reserved bits read set");
  // Main scenarios reached
  cover property (wr_acc && pready_out && paddr_in == 8'h1c);
  cover property (exchange_done_in ##1 page_take_in);
  cover property (pslverr_out);
endmodule // np_next_page_sva

// file: bench/np_arbiter_model.sv
// Arbitration side model: one link code word exchange, then a page take.
// Assumes the bench pulses go_in for one cycle; slow_in stretches the gap.
`timescale 1ns/10ps
module np_arbiter_model (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic go_in,
  input wire logic slow_in,
  output logic exchange_done_out,
  output logic toggle_out,
  output logic page_take_out
);
  logic tog_q;
  logic [2:0] wait_q;
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      tog_q <= 1'b0;
      wait_q <= 3'h0;
      exchange_done_out <= 1'b0;
      page_take_out <= 1'b0;
    end else begin
      exchange_done_out <= go_in;
      page_take_out <= (wait_q == 3'h1);
      if (go_in) begin
        tog_q <= ~tog_q;
        wait_q <= slow_in ? 3'h4 : 3'h1;
      end else if (wait_q != 3'h0) begin
        wait_q <= wait_q - 3'h1;
      end
    end
  end
  // Toggle line shows the inverse outside its strobe so a stale value never passes
  assign toggle_out = exchange_done_out ? tog_q : ~tog_q;
endmodule // np_arbiter_model

// file: bench/an_next_page_transmit_reg_test.sv
// Self-checking bench for the next page transmit register.
// Assumes the design package is compiled first; checker bound below.
`timescale 1ns/10ps
module an_next_page_transmit_reg_test;
  import an_np_pkg::*;
  logic clock_in = 1'b0;
  logic rstn_in = 1'b0;
  logic clk_en_in = 1'b1;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [7:0] paddr_in = 8'h0;
  logic [31:0] pwdata_in = 32'h0;
  logic go = 1'b0;
  logic slow = 1'b0;
  logic [31:0] prdata_out, rd;
  logic pready_out, pslverr_out, er, page_take_in, exchange_done_in;
  logic exchanged_toggle_in, local_pages_capable_out, word_fresh_out;
  an_np_pkg::word_t tx_word_out;
  int error_cnt = 0;
  int tests_run = 0;
  // 100 MHz clock
  always #5 clock_in = ~clock_in;
  an_next_page_transmit_reg #(.ADDR_W(8)) dut (.clock_in, .rstn_in, .clk_en_in,
    .paddr_in, .psel_in, .penable_in, .pwrite_in, .pwdata_in, .prdata_out,
    .pready_out, .pslverr_out, .page_take_in, .exchange_done_in,
    .exchanged_toggle_in, .tx_word_out, .local_pages_capable_out, .word_fresh_out);
  np_arbiter_model arb (.clock_in, .rstn_in, .go_in(go), .slow_in(slow),
    .exchange_done_out(exchange_done_in), .toggle_out(exchanged_toggle_in),
    .page_take_out(page_take_in));
  //****************
  // Tasks
  //****************
  task automatic stop_test;
    $display("Checks %0d, errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Bus cycle; ready and read data are taken at the rising edge that ends the access
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clock_in);
    penable_in <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
    end while (pready_out !== 1'b1 && n < 20);
    if (pready_out !== 1'b1) begin
      error_cnt++;
      stop_test();
    end
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask
  // One exchange then a take; returns a cycle after the take
  task automatic xchg(input logic s);
    int n;
    @(posedge clock_in);
    go <= 1'b1;
    slow <= s;
    @(posedge clock_in);
    go <= 1'b0;
    n = 0;
    do begin
      @(negedge clock_in);
      n++;
    end while (page_take_in !== 1'b1 && n < 20);
    if (page_take_in !== 1'b1) begin
      error_cnt++;
      stop_test();
    end
    @(negedge clock_in);
  endtask
  task t_reset_values;
    rd_chk(8'h1c, 32'h2001, "reset word");
    chk("sent word", 32'h2001, {16'h0, tx_word_out});
    rd_chk(8'h18, 32'h4, "expansion");
    chk("capable", 32'h1, {31'h0, local_pages_capable_out});
  endtask
  task t_write_fields;
    apb(1'b1, 8'h1c, 32'hffffffff);
    rd_chk(8'h1c, 32'hb7ff, "ones word");
    chk("fresh", 32'h1, {31'h0, word_fresh_out});
    apb(1'b1, 8'h1c, 32'h0);
    rd_chk(8'h1c, 32'h0, "zeros word");
  endtask
  task t_exchange;
    apb(1'b1, 8'h1c, 32'hf5a5);
    xchg(1'b0);
    chk("sent word", 32'hb5a5, {16'h0, tx_word_out});
    chk("fresh", 32'h0, {31'h0, word_fresh_out});
    rd_chk(8'h1c, 32'hb5a5, "toggled word");
    xchg(1'b1);
    chk("resent word", 32'hbda5, {16'h0, tx_word_out});
  endtask
  task t_errors;
    rd_chk(8'h40, 32'h0, "unmapped data");
    chk("unmapped err", 32'h1, {31'h0, er});
    rd_chk(8'h1d, 32'h0, "misaligned data");
    apb(1'b1, 8'h18, 32'hffffffff);
    chk("ro write err", 32'h0, {31'h0, er});
    rd_chk(8'h18, 32'h4, "expansion kept");
  endtask
  task t_mid_reset;
    apb(1'b1, 8'h1c, 32'h1234);
    @(posedge clock_in);
    rstn_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    rstn_in <= 1'b1;
    rd_chk(8'h1c, 32'h2001, "word after reset");
    chk("fresh after reset", 32'h0, {31'h0, word_fresh_out});
  endtask
  //****************
  // Main sequence
  //****************
  initial begin
    repeat (16) @(posedge clock_in);
    rstn_in <= 1'b1;
    t_reset_values();
    t_write_fields();
    t_exchange();
    t_errors();
    t_mid_reset();
    stop_test();
  end
endmodule // an_next_page_transmit_reg_test
bind an_next_page_transmit_reg np_next_page_sva #(.ADDR_W(ADDR_W)) u_sva (.clock_in,
  .rstn_in, .clk_en_in, .paddr_in, .psel_in, .penable_in, .pwrite_in, .prdata_out,
  .pready_out, .pslverr_out, .page_take_in, .exchange_done_in, .exchanged_toggle_in,
  .tx_word_out, .local_pages_capable_out, .word_fresh_out);
